// File: hw/iox_pkg.sv
// package for the increment / or / move / jump execution slice
// assumes a 14-bit instruction word fetched one per instruction cycle
//
// Functional notes
// - increment-skip adds one to destination, no flag, skips on zero.
// - destination bit 0 writes accumulator, 1 writes the file register.
// - jump: 11-bit literal to pointer 10:0, page latch 4:3 to 12:11.
// - every jump takes two cycles; the prefetched word is discarded.
// - or-literal ORs 8-bit literal into accumulator, updates null flag.
// - increment adds one to destination, updates null flag, no skip.
// - or-file: accumulator OR file register to destination, null flag.
// - copy moves file register to destination, flag from copied value.
`default_nettype none
package iox_pkg;
	localparam int PTR_W = 13;
	localparam int LIT_W = 11;
	localparam int ADR_W = 7;
	localparam int DAT_W = 8;
	localparam int INSN_W = 14;
	// opcode fields: top six bits for file ops, top three for jump
	localparam logic [5:0] OP_COPY = 6'h08;
	localparam logic [5:0] OP_ORF = 6'h04;
	localparam logic [5:0] OP_INC = 6'h0A;
	localparam logic [5:0] OP_INCSZ = 6'h0F;
	localparam logic [5:0] OP_ORL = 6'h38;
	localparam logic [2:0] OP_JMP = 3'h5;
	localparam int DEST_BIT = 7;
	localparam int PAGE_LO = 3;
	localparam logic [PTR_W-1:0] PTR_RST = 13'h0000;
	localparam logic [DAT_W-1:0] ACC_RST = 8'h00;

	typedef enum {IOX_EXEC, IOX_FLUSH} iox_state_type;

	// file register write request
	typedef struct packed {
		logic en;
		logic [ADR_W-1:0] adr;
		logic [DAT_W-1:0] dat;
	} iox_fwr_type;
endpackage
`default_nettype wire

// File: hw/iox_core.sv
// execution slice: decodes one instruction word per cycle enable
// assumes file register read data is combinational on o_file_adr
// assumes words come from fetch logic on i_clk, so nothing is synchronised
`timescale 1ns/1ps
`default_nettype none
module iox_core (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// instruction stream
	input wire logic i_insn_valid,
	input wire logic [iox_pkg::INSN_W-1:0] i_insn,
	input wire logic [iox_pkg::DAT_W-1:0] i_page_latch_high,
	// file register port
	output logic [iox_pkg::ADR_W-1:0] o_file_adr,
	input wire logic [iox_pkg::DAT_W-1:0] i_file_rdata,
	output iox_pkg::iox_fwr_type o_file_wr,
	// state
	output logic [iox_pkg::DAT_W-1:0] o_accum,
	output logic o_result_null_flag,
	output logic [iox_pkg::PTR_W-1:0] o_instruction_pointer,
	output logic o_idle_slot
);
	// registered state and its next values
	iox_pkg::iox_state_type state_q, state_d;
	logic [iox_pkg::DAT_W-1:0] acc_q, acc_d;
	logic null_q, null_d;
	logic [iox_pkg::PTR_W-1:0] ptr_q, ptr_d;
	iox_pkg::iox_fwr_type fwr_q, fwr_d;

	// opcode decode
	wire [5:0] op6 = i_insn[13:8];
	wire dest_file = i_insn[iox_pkg::DEST_BIT];
	wire is_copy = op6 == iox_pkg::OP_COPY;
	wire is_orf = op6 == iox_pkg::OP_ORF;
	wire is_inc = op6 == iox_pkg::OP_INC;
	wire is_incsz = op6 == iox_pkg::OP_INCSZ;
	wire is_orl = (op6 & 6'h3C) == iox_pkg::OP_ORL;
	wire is_jmp = i_insn[13:11] == iox_pkg::OP_JMP;
	wire is_file_op = is_copy | is_orf | is_inc | is_incsz;
	wire exec = i_insn_valid && state_q == iox_pkg::IOX_EXEC;

	// datapath: increments wrap at 8 bits
	wire [iox_pkg::DAT_W-1:0] inc_res = i_file_rdata + 8'h01;
	wire [iox_pkg::DAT_W-1:0] orf_res = acc_q | i_file_rdata;
	wire [iox_pkg::DAT_W-1:0] orl_res = acc_q | i_insn[7:0];
	wire [iox_pkg::DAT_W-1:0] file_res = is_copy ? i_file_rdata :
		is_orf ? orf_res : inc_res;
	wire skip = is_incsz && inc_res == 8'h00;
	wire [iox_pkg::PTR_W-1:0] jmp_tgt = {i_page_latch_high[4:iox_pkg::PAGE_LO],
		i_insn[iox_pkg::LIT_W-1:0]};

	function automatic logic is_zero(input logic [iox_pkg::DAT_W-1:0] v);
		is_zero = v == 8'h00;
	endfunction

	// next-state: write routing, flag, pointer and flush slot
	always_comb begin
		state_d = iox_pkg::IOX_EXEC;
		acc_d = acc_q;
		null_d = null_q;
		ptr_d = ptr_q;
		fwr_d = '0;
		if (state_q == iox_pkg::IOX_FLUSH && i_insn_valid) begin
			ptr_d = ptr_q + 13'h0001; // squashed word executes as idle
		end else if (state_q == iox_pkg::IOX_FLUSH) begin
			state_d = iox_pkg::IOX_FLUSH;
		end else if (exec) begin
			ptr_d = ptr_q + 13'h0001;
			if (is_jmp) begin
				ptr_d = jmp_tgt;
				state_d = iox_pkg::IOX_FLUSH;
			end else if (is_orl) begin
				acc_d = orl_res;
				null_d = is_zero(orl_res);
			end else if (is_file_op) begin
				if (dest_file) begin
					fwr_d.en = 1'b1;
					fwr_d.adr = i_insn[iox_pkg::ADR_W-1:0];
					fwr_d.dat = file_res;
				end else begin
					acc_d = file_res;
				end
				if (!is_incsz)
					null_d = is_zero(file_res);
				if (skip)
					state_d = iox_pkg::IOX_FLUSH;
			end
		end
	end

	// state registers; short on purpose, all logic lives above
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= iox_pkg::IOX_EXEC;
			acc_q <= iox_pkg::ACC_RST;
			null_q <= 1'b0;
			ptr_q <= iox_pkg::PTR_RST;
			fwr_q <= '0;
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			null_q <= null_d;
			ptr_q <= ptr_d;
			fwr_q <= fwr_d;
		end
	end

	assign o_file_adr = i_insn[iox_pkg::ADR_W-1:0];
	assign o_file_wr = fwr_q;
	assign o_accum = acc_q;
	assign o_result_null_flag = null_q;
	assign o_instruction_pointer = ptr_q;
	assign o_idle_slot = state_q == iox_pkg::IOX_FLUSH; // next word is squashed

	// checks on registered results, one cycle after the taking edge

	// increment-skip: squash exactly when the sum wrapped, flag untouched
	a_skip_zero: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_incsz |=> o_idle_slot == ($past(inc_res) == 8'h00))
		else $error("skip slot wrong after increment-skip");
	a_skip_flag_kept: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_incsz |=> $stable(o_result_null_flag))
		else $error("increment-skip changed null flag");
	a_skip_dest: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_incsz && dest_file |=> o_file_wr.en
			&& o_file_wr.dat == $past(i_file_rdata) + 8'h01)
		else $error("increment-skip wrote wrong value");
	a_incsz_wrap: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_incsz && i_file_rdata == 8'hFF |=> o_idle_slot)
		else $error("increment-skip of a full register did not skip");

	// plain increment: never skips, wraps to zero and sets the flag
	a_inc_no_skip: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_inc |=> !o_idle_slot)
		else $error("increment skipped");
	a_inc_wrap: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_inc && i_file_rdata == 8'hFF |=> o_result_null_flag)
		else $error("increment did not wrap");

	// or-literal: accumulator only, flag follows the new accumulator
	a_orl_acc: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_orl |=> o_accum == ($past(acc_q) | $past(i_insn[7:0])))
		else $error("or-literal result wrong");
	a_orl_flag: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_orl |=> o_result_null_flag == (o_accum == 8'h00))
		else $error("or-literal null flag wrong");

	// destination routing and the one-cycle write pulse
	a_dest_file: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_file_op && dest_file |=> o_file_wr.en && $stable(o_accum))
		else $error("destination file not written");
	a_dest_acc: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_file_op && !dest_file |=> !o_file_wr.en
			&& o_accum == $past(file_res))
		else $error("destination accumulator not written");
	a_wr_target: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_file_op && dest_file |=>
			o_file_wr.adr == $past(i_insn[iox_pkg::ADR_W-1:0]))
		else $error("file write went to the wrong address");
	a_wr_pulse: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_file_wr.en |-> $past(exec && is_file_op && dest_file))
		else $error("file write without a destination-file op");

	// flag and value of the file-register results
	a_null_flag: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && (is_orf || is_copy || is_inc) |=>
			o_result_null_flag == ($past(file_res) == 8'h00))
		else $error("null flag wrong");
	a_copy_value: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_copy && !dest_file |=> o_accum == $past(i_file_rdata))
		else $error("copy value wrong");
	a_orf_value: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_orf && !dest_file |=>
			o_accum == ($past(acc_q) | $past(i_file_rdata)))
		else $error("or-file result wrong");

	// jump and the squashed slot that always follows it
	a_jump_two_cyc: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_jmp |=> o_idle_slot
			&& o_instruction_pointer == $past(jmp_tgt))
		else $error("jump did not flush or load target");
	a_jump_flag: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && is_jmp |=> $stable(o_result_null_flag) && $stable(o_accum))
		else $error("jump touched status");
	a_flush_consume: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_idle_slot && i_insn_valid |=> !o_idle_slot
			&& $stable(o_accum) && $stable(o_result_null_flag)
			&& !o_file_wr.en
			&& o_instruction_pointer == $past(o_instruction_pointer)
				+ 13'h0001)
		else $error("squashed word was not idle");
	a_flush_hold: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_idle_slot && !i_insn_valid |=> o_idle_slot
			&& $stable(o_instruction_pointer))
		else $error("idle slot lost without a word");

	// every word but a jump or a skipping increment-skip takes a single cycle; a foreign word only steps the pointer
	a_single_cycle: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && !is_jmp && !skip |=> !o_idle_slot)
		else $error("single-cycle instruction stalled");
	a_other_word: assert property (
		@(posedge i_clk) disable iff (i_rst)
		exec && !(is_jmp || is_orl || is_file_op) |=> $stable(o_accum)
			&& $stable(o_result_null_flag) && !o_file_wr.en
			&& o_instruction_pointer == $past(o_instruction_pointer)
				+ 13'h0001)
		else $error("foreign word did more than step the pointer");
endmodule
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the execution slice: random words vs a model
// assumes results show at the taking rising edge and are checked at the next falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_insn_valid = 1'b0;
	logic [13:0] i_insn = 14'h0000;
	logic [7:0] i_page_latch_high = 8'h00;
	logic [7:0] i_file_rdata = 8'h00;
	logic [6:0] o_file_adr;
	iox_pkg::iox_fwr_type o_file_wr;
	logic [7:0] o_accum, acc, r;
	logic o_result_null_flag, o_idle_slot, z, idle;
	logic [12:0] o_instruction_pointer, ptr;
	iox_pkg::iox_fwr_type wr;
	logic [13:0] corner [4] = '{14'h3800, 14'h0F00, 14'h2ABC, 14'h0A80};
	int error_cnt = 0;
	int n_checks = 0;
	int seed = 27;
	always #12.5 i_clk = ~i_clk;
	iox_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_insn_valid(i_insn_valid),
		.i_insn(i_insn), .i_page_latch_high(i_page_latch_high),
		.o_file_adr(o_file_adr), .i_file_rdata(i_file_rdata),
		.o_file_wr(o_file_wr), .o_accum(o_accum),
		.o_result_null_flag(o_result_null_flag),
		.o_instruction_pointer(o_instruction_pointer),
		.o_idle_slot(o_idle_slot));
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// reference model: a squashed word only advances the pointer
	function automatic void model(input logic [13:0] w, input logic [7:0] rd);
		logic ld;
		ld = 1'b1;
		wr = '0;
		ptr = ptr + 13'h0001;
		if (idle) begin
			idle = 1'b0;
			return;
		end
		case (w[13:8])
		iox_pkg::OP_COPY: r = rd;
		iox_pkg::OP_ORF: r = acc | rd;
		iox_pkg::OP_INC, iox_pkg::OP_INCSZ: r = rd + 8'h01;
		default: ld = 1'b0;
		endcase
		if (w[13:11] == 3'b101) begin
			ptr = {i_page_latch_high[4:3], w[10:0]};
			idle = 1'b1;
		end else if (w[13:10] == 4'hE) begin
			acc = acc | w[7:0];
			z = (acc == 8'h00);
		end
		if (ld && w[7])
			wr = {1'b1, w[6:0], r};
		else if (ld)
			acc = r;
		if (ld && w[13:8] == iox_pkg::OP_INCSZ)
			idle = (r == 8'h00);
		else if (ld)
			z = (r == 8'h00);
	endfunction
	// watchdog: about twice the expected run length
	initial begin
		#100000;
		error_cnt++;
		final_report();
	end
	initial begin
		{acc, z, idle, ptr, wr} = '0;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		for (int i = 0; i < 2000; i++) begin
			// mid-run reset: model and design both back to reset values
			if (i == 1000) begin
				i_rst = 1'b1;
				{acc, z, idle, ptr, wr} = '0;
				@(negedge i_clk);
				chk("rst_accum", 16'h0000, 16'(o_accum));
				chk("rst_flag", 16'h0000, 16'(o_result_null_flag));
				chk("rst_ptr", 16'h0000, 16'(o_instruction_pointer));
				chk("rst_idle", 16'h0000, 16'(o_idle_slot));
				chk("rst_wr", 16'h0000, o_file_wr);
				i_rst = 1'b0;
			end
			i_insn_valid = (i < 4) || ($random(seed) % 8 != 0);
			i_insn = (i < 4) ? corner[i] : 14'($random(seed));
			case ($unsigned($random(seed)) % 7)
			0: i_insn[13:8] = iox_pkg::OP_COPY;
			1: i_insn[13:8] = iox_pkg::OP_ORF;
			2: i_insn[13:8] = iox_pkg::OP_INC;
			3: i_insn[13:8] = iox_pkg::OP_INCSZ;
			4: i_insn[13:10] = 4'hE;
			5: i_insn[13:11] = 3'b101;
			default: ;
			endcase
			if (i < 4)
				i_insn = corner[i];
			// a full register often, so wrap and skip are hit
			i_file_rdata = (i < 4 || $random(seed) % 4 == 0) ? 8'hFF :
				8'($random(seed));
			i_page_latch_high = 8'($random(seed));
			if (i_insn_valid)
				model(i_insn, i_file_rdata);
			else
				wr = '0;
			@(negedge i_clk);
			chk("file_adr", 16'(i_insn[6:0]), 16'(o_file_adr));
			chk("file_wr", wr, o_file_wr);
			chk("accum", 16'(acc), 16'(o_accum));
			chk("flag", 16'(z), 16'(o_result_null_flag));
			chk("ptr", 16'(ptr), 16'(o_instruction_pointer));
			chk("idle", 16'(idle), 16'(o_idle_slot));
		end
		final_report();
	end
endmodule
`default_nettype wire
